// ---- core/avcmb_fifo.sv ----
// Payload FIFO with registered read data and registered ready
`timescale 1ns/100ps
`default_nettype none
module avcmb_fifo
  import avcmb_pkg::*;
#(
  parameter int unsigned W     = 33,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FREE_MIN = CW'(DEPTH - FIFO_SLACK);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [CW-1:0]           cnt;
    logic                    rdy;
    logic                    ov;
    logic [W-1:0]            od;
  } avcmb_fifo_s;

  avcmb_fifo_s fifo_reg;
  avcmb_fifo_s fifo_next;

  // Write, refill the output register, and recompute ready
  always_comb begin
    fifo_next = fifo_reg;
    if (out_ready) begin
      fifo_next.ov = 1'b0;
    end
    if (in_valid && fifo_reg.cnt < CW'(DEPTH)) begin
      fifo_next.mem[fifo_reg.wr] = in_data;
      fifo_next.wr = fifo_reg.wr + 1'b1;
      fifo_next.cnt = fifo_next.cnt + 1'b1;
    end
    if (!fifo_next.ov && fifo_reg.cnt != '0) begin
      fifo_next.od = fifo_reg.mem[fifo_reg.rd];
      fifo_next.ov = 1'b1;
      fifo_next.rd = fifo_reg.rd + 1'b1;
      fifo_next.cnt = fifo_next.cnt - 1'b1;
    end
    fifo_next.rdy = fifo_next.cnt <= FREE_MIN; // Room for words in flight
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      fifo_reg <= '0;
    end else begin
      fifo_reg <= fifo_next;
    end
  end

  assign in_ready  = fifo_reg.rdy;
  assign out_valid = fifo_reg.ov;
  assign out_data  = fifo_reg.od;
endmodule
`default_nettype wire

// ---- core/avcmb_parser.sv ----
// Per-macroblock inline payload parser for extended media object commands
`timescale 1ns/100ps
`default_nettype none
module avcmb_parser
  import avcmb_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 32
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Command stream in
  input  wire logic        cmd_valid,
  input  wire logic [31:0] cmd_data,
  input  wire logic        cmd_last,
  output logic             cmd_ready,
  // Static configuration
  input  wire logic        h264_it_mode,
  input  wire logic [3:0]  fe_state_mask,
  // Thread payload out
  output logic             pay_valid,
  output logic [31:0]      pay_data,
  output logic             pay_last,
  input  wire logic        pay_ready,
  // Scoreboard terms
  output logic [8:0]       sb_y,
  output logic [8:0]       sb_x,
  output logic [3:0]       sb_dep,
  // Decoded macroblock parameters
  output logic             mb_info_valid,
  output logic             mb_reserved_code,
  output logic [1:0]       adaptive_field_mb_code,
  output logic             bottom_field_polarity,
  output logic [2:0]       desc_field_bits,
  output logic [2:0]       motion_vector_count_code,
  output logic [5:0]       motion_vector_total,
  output logic             luma_dc_coded,
  output logic             cb_dc_coded,
  output logic             cr_dc_coded,
  output logic             large_transform_select,
  output logic             field_macroblock,
  output logic             intra_macroblock,
  output logic [4:0]       macroblock_kind,
  output logic [1:0]       bidir_weighting_mode,
  output logic             explicit_weighting,
  output logic             left_row7_available,
  output logic [1:0]       chroma_sampling_code,
  output logic             adaptive_frame_picture,
  output logic             field_picture,
  output logic [15:0]      luma_coded_pattern,
  output logic [7:0]       mb_row_position,
  output logic [7:0]       mb_column_position,
  output logic [7:0]       cr_quantizer,
  output logic [7:0]       cb_quantizer,
  output logic [7:0]       luma_quantizer,
  output logic [3:0]       cr_coded_pattern,
  output logic [3:0]       cb_coded_pattern
);

  typedef enum logic [1:0] {
    ST_BODY,
    ST_PAD
  } avcmb_state_e;

  typedef struct packed {
    avcmb_state_e st;
    logic [7:0]   idx;
    logic [2:0]   fill;
    logic         rdy;
    logic         pv;
    logic [31:0]  pd;
    logic         pl;
    logic [8:0]   sby;
    logic [8:0]   sbx;
    logic [3:0]   dep;
    logic         iv;
    logic         bad;
    logic [31:0]  w0;
    logic [31:0]  w1;
    logic [31:0]  w2;
    logic [5:0]   mvt;
    logic [1:0]   wgt;
  } avcmb_state_s;

  avcmb_state_s st_reg;
  avcmb_state_s st_next;
  logic         fifo_in_ready;

  // Number of motion vectors a count code stands for
  function automatic logic [5:0] mv_total(input logic [2:0] code);
    case (code)
      MV_ONE_PAIR:   mv_total = 6'd2;
      MV_FOUR_PAIRS: mv_total = 6'd8;
      MV_SIXTEEN:    mv_total = 6'd16;
      MV_SIXTEEN_PR: mv_total = 6'd32;
      default:       mv_total = 6'd0;
    endcase
  endfunction

  // Reserved or inconsistent codes in inline dword 0
  function automatic logic reserved_code(input logic [31:0] w);
    logic [2:0] mv;
    logic       bad;
    mv  = w[MV_LSB +: 3];
    bad = 1'b0;
    if (mv != MV_NONE && mv_total(mv) == 6'd0) begin
      bad = 1'b1;
    end
    if (w[INTRA_BIT] && mv != MV_NONE) begin
      bad = 1'b1;
    end
    if (!w[INTRA_BIT] && w[WBI_LSB +: 2] == WGT_RESERVED) begin
      bad = 1'b1;
    end
    if (w[CHR_LSB +: 2] != CHR_MONO && w[CHR_LSB +: 2] != CHR_420) begin
      bad = 1'b1;
    end
    if (w[FPIC_BIT] && w[AFP_BIT]) begin
      bad = 1'b1;
    end
    if (w[AFF_LSB +: 2] != AFF_FRAME && w[AFF_LSB +: 2] != AFF_FIELD) begin
      bad = 1'b1;
    end
    return bad;
  endfunction

  // Word that takes the three quantizer slots (bits 31:8) of inline dword 2
  function automatic logic [23:0] derived_info(input logic [31:0] w);
    return {2'b00, mv_total(w[MV_LSB +: 3]),
            5'b0_0000, w[DC_LSB +: 3],
            w[T8_BIT], w[FMB_BIT], w[INTRA_BIT], w[KIND_LSB +: 5]};
  endfunction

  // Payload FIFO toward the thread register file
  avcmb_fifo #(
    .W     (DW + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (st_reg.pv),
    .in_data   ({st_reg.pl, st_reg.pd}),
    .in_ready  (fifo_in_ready),
    .out_valid (pay_valid),
    .out_data  ({pay_last, pay_data}),
    .out_ready (pay_ready)
  );

  // Command walk, field capture and payload shaping
  always_comb begin
    logic        acc;
    logic [7:0]  in_idx;
    logic [31:0] w;
    acc     = cmd_valid && st_reg.rdy;
    in_idx  = st_reg.idx - INLINE_FIRST;
    w       = cmd_data;
    st_next = st_reg;
    st_next.pv = 1'b0;
    st_next.pl = 1'b0;
    st_next.iv = 1'b0;
    case (st_reg.st)
      ST_BODY: begin
        if (acc) begin
          if (st_reg.idx != 8'hFF) begin
            st_next.idx = st_reg.idx + 1'b1;
          end
          if (st_reg.idx == MODE_DWORD) begin
            st_next.sby = cmd_data[SB_Y_LSB +: 9];
            st_next.sbx = cmd_data[SB_X_LSB +: 9];
            st_next.dep = cmd_data[SB_MASK_LSB +: 4] & fe_state_mask;
          end
          if (st_reg.idx >= INLINE_FIRST) begin
            if (h264_it_mode && in_idx == 8'd0) begin
              st_next.w0 = cmd_data;
              st_next.bad = reserved_code(cmd_data);
              st_next.mvt = cmd_data[INTRA_BIT] ? 6'd0 : mv_total(cmd_data[MV_LSB +: 3]);
              st_next.wgt = cmd_data[INTRA_BIT] ? 2'b00 : cmd_data[WBI_LSB +: 2];
              w[DC_LSB +: 3] = 3'b000;
            end
            if (h264_it_mode && in_idx == 8'd1) begin
              st_next.w1 = cmd_data;
            end
            if (h264_it_mode && in_idx == 8'd2) begin
              st_next.w2 = cmd_data;
              st_next.iv = 1'b1;
              w[31:QY_LSB] = derived_info(st_reg.w0);
            end
            st_next.pv = 1'b1;
            st_next.pd = w;
            st_next.fill = st_reg.fill + 1'b1;
            st_next.pl = cmd_last && st_reg.fill == 3'(GRF_DWORDS - 1);
          end
          if (cmd_last) begin
            st_next.idx = 8'd0;
            if (st_reg.idx >= INLINE_FIRST && st_next.fill != 3'd0) begin
              st_next.st = ST_PAD;
            end
          end
        end
      end
      ST_PAD: begin
        if (fifo_in_ready) begin
          st_next.pv = 1'b1;
          st_next.pd = RST_WORD;
          st_next.fill = st_reg.fill + 1'b1;
          if (st_reg.fill == 3'(GRF_DWORDS - 1)) begin
            st_next.pl = 1'b1;
            st_next.st = ST_BODY;
          end
        end
      end
      default: begin
        st_next.st = ST_BODY;
      end
    endcase
    // Accept input only in the body and only with FIFO room
    st_next.rdy = st_next.st == ST_BODY && fifo_in_ready;
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Handshake and scoreboard outputs
  assign cmd_ready        = st_reg.rdy;
  assign sb_y             = st_reg.sby;
  assign sb_x             = st_reg.sbx;
  assign sb_dep           = st_reg.dep;
  assign mb_info_valid    = st_reg.iv;
  assign mb_reserved_code = st_reg.bad;

  // Inline dword 0 fields
  assign adaptive_field_mb_code   = st_reg.w0[AFF_LSB +: 2];
  assign bottom_field_polarity    = st_reg.w0[POL_BIT];
  assign desc_field_bits          = st_reg.w0[POL_BIT +: 3];
  assign motion_vector_count_code = st_reg.w0[MV_LSB +: 3];
  assign luma_dc_coded            = st_reg.w0[DC_LSB + 2];
  assign cb_dc_coded              = st_reg.w0[DC_LSB + 1];
  assign cr_dc_coded              = st_reg.w0[DC_LSB];
  assign large_transform_select   = st_reg.w0[T8_BIT];
  assign field_macroblock         = st_reg.w0[FMB_BIT];
  assign intra_macroblock         = st_reg.w0[INTRA_BIT];
  assign macroblock_kind          = st_reg.w0[KIND_LSB +: 5];
  assign explicit_weighting       = st_reg.w0[WP_BIT];
  assign left_row7_available      = st_reg.w0[LR7_BIT];
  assign chroma_sampling_code     = st_reg.w0[CHR_LSB +: 2];
  assign adaptive_frame_picture   = st_reg.w0[AFP_BIT];
  assign field_picture            = st_reg.w0[FPIC_BIT];

  // Weighting reads as default for intra macroblocks
  assign bidir_weighting_mode = st_reg.wgt;

  // Count of vectors, zero for intra macroblocks
  assign motion_vector_total = st_reg.mvt;

  // Inline dword 1 fields
  assign luma_coded_pattern = st_reg.w1[LUMA_CODED_PATTERN_LSB +: 16];
  assign mb_row_position    = st_reg.w1[ROW_LSB +: 8];
  assign mb_column_position = st_reg.w1[COL_LSB +: 8];

  // Inline dword 2 fields
  assign cr_quantizer     = st_reg.w2[QCR_LSB +: 8];
  assign cb_quantizer     = st_reg.w2[QCB_LSB +: 8];
  assign luma_quantizer   = st_reg.w2[QY_LSB +: 8];
  assign cr_coded_pattern = st_reg.w2[CR_CODED_PATTERN_LSB +: 4];
  assign cb_coded_pattern = st_reg.w2[CB_CODED_PATTERN_LSB +: 4];
endmodule
`default_nettype wire

// ---- core/avcmb_pkg.sv ----
// Constants shared by the inline payload parser and its FIFO
package avcmb_pkg;
  localparam int unsigned DW            = 32;
  localparam int unsigned GRF_DWORDS    = 8;
  localparam logic [7:0]  MODE_DWORD    = 8'h01;
  localparam logic [7:0]  INLINE_FIRST  = 8'h04;
  // Mode dword
  localparam int unsigned SB_Y_LSB      = 16;
  localparam int unsigned SB_MASK_LSB   = 12;
  localparam int unsigned SB_X_LSB      = 0;
  // Inline dword 0
  localparam int unsigned AFF_LSB       = 25;
  localparam int unsigned POL_BIT       = 24;
  localparam int unsigned MV_LSB        = 20;
  localparam int unsigned DC_LSB        = 17;
  localparam int unsigned T8_BIT        = 15;
  localparam int unsigned FMB_BIT       = 14;
  localparam int unsigned INTRA_BIT     = 13;
  localparam int unsigned KIND_LSB      = 8;
  localparam int unsigned WBI_LSB       = 6;
  localparam int unsigned WP_BIT        = 5;
  localparam int unsigned LR7_BIT       = 4;
  localparam int unsigned CHR_LSB       = 2;
  localparam int unsigned AFP_BIT       = 1;
  localparam int unsigned FPIC_BIT      = 0;
  // Block-read descriptor bit that lines up with the polarity bit
  localparam int unsigned DESC_LSB      = 8;
  // Inline dword 1
  localparam int unsigned LUMA_CODED_PATTERN_LSB      = 16;
  localparam int unsigned ROW_LSB       = 8;
  localparam int unsigned COL_LSB       = 0;
  // Inline dword 2
  localparam int unsigned QCR_LSB       = 24;
  localparam int unsigned QCB_LSB       = 16;
  localparam int unsigned QY_LSB        = 8;
  localparam int unsigned CR_CODED_PATTERN_LSB     = 4;
  localparam int unsigned CB_CODED_PATTERN_LSB     = 0;
  // Motion vector count codes
  localparam logic [2:0]  MV_NONE       = 3'h0;
  localparam logic [2:0]  MV_ONE_PAIR   = 3'h2;
  localparam logic [2:0]  MV_FOUR_PAIRS = 3'h4;
  localparam logic [2:0]  MV_SIXTEEN    = 3'h5;
  localparam logic [2:0]  MV_SIXTEEN_PR = 3'h6;
  // Chroma sampling, weighting and adaptive field codes
  localparam logic [1:0]  CHR_MONO      = 2'h0;
  localparam logic [1:0]  CHR_420       = 2'h1;
  localparam logic [1:0]  WGT_RESERVED  = 2'h3;
  localparam logic [1:0]  AFF_FRAME     = 2'h0;
  localparam logic [1:0]  AFF_FIELD     = 2'h3;
  // Reset values
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  // FIFO keeps this many free slots when it says ready
  localparam int unsigned FIFO_SLACK    = 3;
endpackage

// ---- verification/avc_mb_inline_payload_parser_tb.sv ----
// Self-checking bench for the inline payload parser
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module avc_mb_inline_payload_parser_tb
  import avcmb_pkg::*;
;
  logic        mclk, rst, cmd_valid, cmd_last, h264_it_mode, stall, slow;
  logic [31:0] cmd_data, seed;
  logic [3:0]  fe_state_mask;
  logic        cmd_ready, pay_valid, pay_last, pay_ready, mb_info_valid, mb_reserved_code;
  logic        large_transform_select, field_macroblock;
  logic [31:0] pay_data;
  logic [5:0]  motion_vector_total;
  logic [1:0]  bidir_weighting_mode;
  logic [7:0]  luma_quantizer;
  logic [32:0] pay_q[$];
  logic [18:0] mb_q[$];
  logic [32:0] pexp;
  logic [18:0] mexp;
  logic [18:0] mgot;
  int          checks, n_errors, t;
  int          lens[8] = '{3, 8, 9, 16, 1, 0, 5, 12};
  avcmb_parser avcmb_parser_i (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_ready(cmd_ready),
    .h264_it_mode(h264_it_mode), .fe_state_mask(fe_state_mask), .pay_valid(pay_valid),
    .pay_data(pay_data), .pay_last(pay_last), .pay_ready(pay_ready), .sb_y(), .sb_x(),
    .sb_dep(), .mb_info_valid(mb_info_valid), .mb_reserved_code(mb_reserved_code),
    .adaptive_field_mb_code(), .bottom_field_polarity(), .desc_field_bits(),
    .motion_vector_count_code(), .motion_vector_total(motion_vector_total),
    .luma_dc_coded(), .cb_dc_coded(), .cr_dc_coded(),
    .large_transform_select(large_transform_select), .field_macroblock(field_macroblock),
    .intra_macroblock(), .macroblock_kind(), .bidir_weighting_mode(bidir_weighting_mode),
    .explicit_weighting(), .left_row7_available(), .chroma_sampling_code(),
    .adaptive_frame_picture(), .field_picture(), .luma_coded_pattern(),
    .mb_row_position(), .mb_column_position(), .cr_quantizer(), .cb_quantizer(),
    .luma_quantizer(luma_quantizer), .cr_coded_pattern(), .cb_coded_pattern());
  avcmb_drain_model avcmb_drain_model_i (.mclk(mclk), .rst(rst), .stall(stall), .slow(slow),
    .pay_ready(pay_ready));
  // Random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected vector total for an inline dword 0
  function automatic logic [5:0] mv_total(input logic [31:0] d0);
    if (d0[13]) return 6'h00;
    case (d0[22:20])
      MV_ONE_PAIR: return 6'h02;
      MV_FOUR_PAIRS: return 6'h08;
      MV_SIXTEEN: return 6'h10;
      MV_SIXTEEN_PR: return 6'h20;
      default: return 6'h00;
    endcase
  endfunction
  // Expected flag for a reserved or inconsistent dword 0
  function automatic logic resv(input logic [31:0] d0);
    return d0[22:20] inside {3'h1, 3'h3, 3'h7} || (d0[13] && d0[22:20] != MV_NONE)
      || (!d0[13] && d0[7:6] == WGT_RESERVED) || d0[3] || (d0[1] && d0[0])
      || d0[26:25] inside {2'h1, 2'h2};
  endfunction
  // Drive one command at falling edges and note its expected results
  task automatic send_cmd(input int n, input logic mode, input logic [2:0] mv, input logic legal);
    logic [31:0] w;
    logic [31:0] d[$];
    int m;
    seed = lfsr(seed);
    d = {32'h7101_0000, seed & 32'h01FF_F1FF, 32'h0000_0000, 32'h0000_0000};
    for (int i = 0; i < n; i++) begin
      seed = lfsr(seed);
      w = seed;
      if (i == 0) begin
        w[22:20] = mv;
        if (legal) begin
          w[1] = w[1] & ~w[0];
          w[26:25] = {2{w[1] & w[14]}};
          if (!w[0] && !w[26]) w[24] = 1'b0;
          w[4] = seed[8] & seed[9];
          {w[31:27], w[23], w[16]} = 7'h00;
          w[3] = 1'b0;
          w[13] = (mv == MV_NONE);
          w[7] = 1'b0;
          if (w[13]) w[7:5] = 3'h0;
        end
      end
      d.push_back(w);
    end
    for (int i = 4; i < d.size(); i++) begin
      w = d[i];
      if (mode && i == 4) w[19:17] = 3'h0;
      // The derived count in the payload ignores the intra bit
      if (mode && i == 6) begin
        w[31:8] = {2'h0, mv_total(d[4] & 32'hFFFF_DFFF), 5'h00, d[4][19:17],
                   d[4][15:8]};
      end
      pay_q.push_back({1'b0, w});
    end
    for (m = n; m % 8 != 0; m++) pay_q.push_back(33'h0_0000_0000);
    if (n > 0) pay_q[pay_q.size() - 1][32] = 1'b1;
    if (mode && n >= 3) begin
      mb_q.push_back({resv(d[4]), mv_total(d[4]), d[4][13] ? 2'h0 : d[4][7:6], d[4][15:14],
        d[6][15:8]});
    end
    h264_it_mode = mode;
    fe_state_mask = seed[7:4];
    for (int i = 0; i < d.size(); i++) begin
      cmd_valid = 1'b1;
      cmd_data = d[i];
      cmd_last = (i == d.size() - 1);
      m = 0;
      do begin
        @(posedge mclk);
        m++;
      end while (!cmd_ready && m < 3000);
      if (!cmd_ready) n_errors++;
      @(negedge mclk);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Take the oldest note whenever the design shows a result
  always @(posedge mclk) begin
    if (!rst && pay_valid && pay_ready) begin
      pexp = (pay_q.size() > 0) ? pay_q.pop_front() : 33'h1_FFFF_FFFF;
      `CHK({pay_last, pay_data}, pexp)
    end
    if (!rst && mb_info_valid) begin
      mexp = (mb_q.size() > 0) ? mb_q.pop_front() : 19'h7_FFFF;
      mgot = {mb_reserved_code, motion_vector_total, bidir_weighting_mode,
              large_transform_select, field_macroblock, luma_quantizer};
      `CHK(mgot, mexp)
    end
  end
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    print_verdict();
  end
  // Main sequence: every vector code, odd lengths, raw mode, then a full stall
  initial begin
    {rst, cmd_valid, cmd_last, h264_it_mode, stall, slow} = 6'b100000;
    cmd_data = 32'h0000_0000;
    fe_state_mask = 4'h0;
    checks = 0;
    n_errors = 0;
    seed = 32'h0000_0036;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    for (int k = 0; k < 8; k++) begin
      slow = k[0];
      send_cmd(lens[k], 1'b1, k[2:0], !k[0]);
    end
    send_cmd(6, 1'b0, MV_ONE_PAIR, 1'b0);
    stall = 1'b1;
    fork
      send_cmd(40, 1'b1, MV_SIXTEEN, 1'b1);
      begin
        repeat (120) @(negedge mclk);
        `CHK(cmd_ready, 1'b0)
        stall = 1'b0;
      end
    join
    cmd_valid = 1'b0;
    for (t = 0; t < 2000 && pay_q.size() > 0; t++) @(negedge mclk);
    repeat (4) @(negedge mclk);
    `CHK(pay_q.size() + mb_q.size(), 0)
    `CHK(pay_valid, 1'b0)
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- verification/avcmb_drain_model.sv ----
// Drain-side model of the thread dispatch path
`timescale 1ns/100ps
`default_nettype none
module avcmb_drain_model (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Pacing control from the bench
  input  wire logic stall,
  input  wire logic slow,
  // Payload handshake
  output var logic  pay_ready
);
  logic [1:0] tick;
  // Ready moves after the falling edge; slow mode takes one beat in three
  initial begin
    pay_ready = 1'b0;
    tick = 2'h0;
    forever begin
      @(negedge mclk);
      tick = (tick == 2'h2) ? 2'h0 : tick + 2'h1;
      pay_ready = !rst && !stall && (!slow || tick == 2'h0);
    end
  end
endmodule
`default_nettype wire

// ---- verification/avcmb_parser_sva.sv ----
// Port checker for the inline payload parser
`timescale 1ns/100ps
`default_nettype none
module avcmb_parser_sva (
  // Clock, reset and command side
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic [31:0] cmd_data,
  input wire logic        cmd_last,
  input wire logic        cmd_ready,
  input wire logic        h264_it_mode,
  input wire logic [3:0]  fe_state_mask,
  // Observed results
  input wire logic        pay_valid,
  input wire logic        pay_last,
  input wire logic [8:0]  sb_y,
  input wire logic [8:0]  sb_x,
  input wire logic [3:0]  sb_dep,
  input wire logic        mb_info_valid,
  input wire logic [1:0]  adaptive_field_mb_code,
  input wire logic        bottom_field_polarity,
  input wire logic [2:0]  desc_field_bits,
  input wire logic [2:0]  motion_vector_count_code,
  input wire logic        luma_dc_coded,
  input wire logic        cb_dc_coded,
  input wire logic        cr_dc_coded,
  input wire logic        intra_macroblock,
  input wire logic [1:0]  bidir_weighting_mode,
  input wire logic [15:0] luma_coded_pattern,
  input wire logic [7:0]  luma_quantizer,
  // Remaining decoded fields
  input wire logic [4:0]  macroblock_kind,
  input wire logic        explicit_weighting,
  input wire logic        left_row7_available,
  input wire logic [1:0]  chroma_sampling_code,
  input wire logic        adaptive_frame_picture,
  input wire logic        field_picture,
  input wire logic [7:0]  mb_row_position,
  input wire logic [7:0]  mb_column_position,
  input wire logic [7:0]  cr_quantizer,
  input wire logic [7:0]  cb_quantizer,
  input wire logic [3:0]  cr_coded_pattern,
  input wire logic [3:0]  cb_coded_pattern
);
  logic [7:0] pos_reg;
  logic [7:0] pos_next;
  logic       take;
  assign take = cmd_valid && cmd_ready;
  // Position of the next dword inside its command, saturating
  always_comb begin
    pos_next = pos_reg;
    if (take) begin
      pos_next = cmd_last ? 8'h00 : ((pos_reg == 8'hff) ? pos_reg : pos_reg + 8'h01);
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      pos_reg <= 8'h00;
    end else begin
      pos_reg <= pos_next;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Scoreboard terms from the mode dword
  property p_sb_y; take && pos_reg == 8'h01 |=> sb_y == $past(cmd_data[24:16]); endproperty
  property p_sb_x; take && pos_reg == 8'h01 |=> sb_x == $past(cmd_data[8:0]); endproperty
  property p_sb_dep;
    take && pos_reg == 8'h01 |=> sb_dep == $past(cmd_data[15:12] & fe_state_mask);
  endproperty
  // Decoded inline fields, one edge after their dword; intra weighting while mb_info_valid is high
  sequence s_d0; take && h264_it_mode && pos_reg == 8'h04; endsequence
  property p_mv; s_d0 |=> motion_vector_count_code == $past(cmd_data[22:20]); endproperty
  property p_dc;
    s_d0 |=> {luma_dc_coded, cb_dc_coded, cr_dc_coded} == $past(cmd_data[19:17]);
  endproperty
  property p_intra; s_d0 |=> intra_macroblock == $past(cmd_data[13]); endproperty
  property p_desc; s_d0 |=> desc_field_bits == $past(cmd_data[26:24]); endproperty
  property p_d0;
    s_d0 |=> {macroblock_kind, explicit_weighting, left_row7_available, chroma_sampling_code,
              adaptive_frame_picture, field_picture} == $past({cmd_data[12:8], cmd_data[5:0]});
  endproperty
  property p_wgt; mb_info_valid && intra_macroblock |-> bidir_weighting_mode == 2'h0; endproperty
  property p_d1;
    take && h264_it_mode && pos_reg == 8'h05
      |=> {luma_coded_pattern, mb_row_position, mb_column_position} == $past(cmd_data);
  endproperty
  property p_d2;
    take && h264_it_mode && pos_reg == 8'h06
      |=> mb_info_valid && {cr_quantizer, cb_quantizer, luma_quantizer, cr_coded_pattern,
                            cb_coded_pattern} == $past(cmd_data) ##1 !mb_info_valid;
  endproperty
  a_sb_y: assert property (p_sb_y) else $error("scoreboard Y wrong");
  a_sb_x: assert property (p_sb_x) else $error("scoreboard X wrong");
  a_sb_dep: assert property (p_sb_dep) else $error("scoreboard mask wrong");
  a_mv: assert property (p_mv) else $error("vector code wrong");
  a_dc: assert property (p_dc) else $error("dc flags wrong");
  a_intra: assert property (p_intra) else $error("intra flag wrong");
  a_desc: assert property (p_desc) else $error("descriptor bits wrong");
  a_d0: assert property (p_d0) else $error("dword 0 fields wrong");
  a_wgt: assert property (p_wgt) else $error("weighting not cleared");
  a_d1: assert property (p_d1) else $error("pattern or origin wrong");
  a_d2: assert property (p_d2) else $error("quantizer or pulse wrong");
  // Main scenarios
  c_pulse: cover property (mb_info_valid);
  c_hold: cover property (cmd_valid && !cmd_ready);
  c_last: cover property (pay_valid && pay_last);
endmodule
bind avcmb_parser avcmb_parser_sva avcmb_parser_sva_i (
  .mclk, .rst, .cmd_valid, .cmd_data, .cmd_last, .cmd_ready, .h264_it_mode, .fe_state_mask,
  .pay_valid, .pay_last, .sb_y, .sb_x, .sb_dep, .mb_info_valid, .adaptive_field_mb_code,
  .bottom_field_polarity, .desc_field_bits, .motion_vector_count_code, .luma_dc_coded,
  .cb_dc_coded, .cr_dc_coded, .intra_macroblock, .bidir_weighting_mode,
  .luma_coded_pattern, .luma_quantizer, .macroblock_kind, .explicit_weighting,
  .left_row7_available, .chroma_sampling_code, .adaptive_frame_picture, .field_picture,
  .mb_row_position, .mb_column_position, .cr_quantizer, .cb_quantizer, .cr_coded_pattern,
  .cb_coded_pattern
);
`default_nettype wire
